// [pmwc_top.sv]
// Summary of operation
// - idle gates cpu and memory clocks only
// - any interrupt returns idle to active
// - standby exits only on pin, timer, sensor
// - standby resumes in place, retention kept
// - gpio latched during whole standby
// - shutdown powers off all, gpio latched
// - shutdown wake pin change acts as reset
// - reset cause separates pin, wake, power-on
// - shutdown keeps only gpio latch, sram retention
// - wake delays 14, 151, 1015 us
// - always-on timer wakes from standby only
// - droop detector on only during recharge in standby
// - four sram blocks, separate retention controls
// - cache off makes cache usable ram
// - always-on domain powered except shutdown
// - sensor processor runs without cpu wake
// - fast crystal doubled to high-speed clock
// - internal slow oscillator when no crystal
// - active runs from any fast source
//
// Added by the designer: the address map and the Wishbone register port.
`timescale 1ns/1ns
`include "pmwc_cfg.svh"

module pmwc_top (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // wake and event sources
    input wire logic irq_any,
    input wire logic rtc_event,
    input wire logic sensor_event,
    input wire logic reset_pin_n,
    input wire logic [`PMWC_NUM_GPIO-1:0] gpio_in,
    input wire logic [`PMWC_NUM_GPIO-1:0] shutdown_wake_mask,
    input wire logic recharge_active,
    input wire logic supply_low,
    input wire logic slow_xtal_present,
    // power and clock control
    output pmwc_pkg::pmwc_gate_t gate_o,
    output logic [`PMWC_NUM_SRAM-1:0] sram_retain_o,
    output logic cache_as_ram_o,
    output logic gpio_latch_o,
    output logic [`PMWC_NUM_GPIO-1:0] gpio_hold_o,
    output logic droop_det_en_o,
    output logic fast_clk_sel_xtal_o,
    output logic fast_pll_x2_en_o,
    output logic slow_clk_sel_xtal_o,
    output logic cpu_reset_o,
    output logic cpu_active_o
);

    // input synchronisers
    logic [2:0] ev_s1, ev_s2;
    logic rpin_s1, rpin_s2;
    logic [`PMWC_NUM_GPIO-1:0] gpio_s1, gpio_s2, gpio_prev;
    logic [1:0] sup_s1, sup_s2;
    logic xtal_s1, xtal_s2;

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ev_s1 <= 3'h0;
            ev_s2 <= 3'h0;
            rpin_s1 <= 1'h1;
            rpin_s2 <= 1'h1;
            gpio_s1 <= 16'h0000;
            gpio_s2 <= 16'h0000;
            sup_s1 <= 2'h0;
            sup_s2 <= 2'h0;
            xtal_s1 <= 1'h0;
            xtal_s2 <= 1'h0;
        end
        else
        begin
            ev_s1 <= {irq_any, rtc_event, sensor_event};
            ev_s2 <= ev_s1;
            rpin_s1 <= reset_pin_n;
            rpin_s2 <= rpin_s1;
            gpio_s1 <= gpio_in;
            gpio_s2 <= gpio_s1;
            sup_s1 <= {recharge_active, supply_low};
            sup_s2 <= sup_s1;
            xtal_s1 <= slow_xtal_present;
            xtal_s2 <= xtal_s1;
        end
    end

    logic irq_s, rtc_s, sensor_s, recharge_s, low_s;
    assign irq_s = ev_s2[2];
    assign rtc_s = ev_s2[1];
    assign sensor_s = ev_s2[0];
    assign recharge_s = sup_s2[1];
    assign low_s = sup_s2[0];

    // registers
    pmwc_pkg::pmwc_mode_t mode_reg, mode_next, from_reg;
    logic [1:0] req_reg;
    logic [`PMWC_NUM_SRAM-1:0] retain_reg;
    pmwc_pkg::pmwc_wake_t wakeen_reg;
    logic [2:0] clksel_reg;
    pmwc_pkg::pmwc_cause_t cause_reg;
    logic droop_lock_reg;
    logic [19:0] wait_reg;
    logic go_pulse;
    logic pin_wake;
    logic rpin_seen_reg;

    // shutdown wake: level change on any masked pin against the latched value
    assign pin_wake = |((gpio_s2 ^ gpio_hold_o) & shutdown_wake_mask);

    // wishbone: one-cycle ack, err on unmapped address
    logic bus_req;
    logic addr_ok;
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign addr_ok = (wb_adr_i == `PMWC_OFF_CTRL) || (wb_adr_i == `PMWC_OFF_STATUS) ||
                     (wb_adr_i == `PMWC_OFF_RSTCAUSE) || (wb_adr_i == `PMWC_OFF_RETAIN) ||
                     (wb_adr_i == `PMWC_OFF_WAKEEN) || (wb_adr_i == `PMWC_OFF_CLKSEL) ||
                     (wb_adr_i == `PMWC_OFF_GPIO);
    assign go_pulse = bus_req && addr_ok && wb_we_i && wb_sel_i[0] && (wb_adr_i == `PMWC_OFF_CTRL)
                      && wb_dat_i[`PMWC_CTRL_GO_BIT] && (wb_dat_i[1:0] != 2'h0);

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wb_ack_o <= 1'h0;
            wb_err_o <= 1'h0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= bus_req && addr_ok;
            wb_err_o <= bus_req && !addr_ok;
            wb_dat_o <= 32'h00000000;
            if (bus_req && !wb_we_i)
            begin
                case (wb_adr_i)
                    `PMWC_OFF_CTRL: wb_dat_o <= {30'h0, req_reg};
                    `PMWC_OFF_STATUS: wb_dat_o <= {27'h0, droop_lock_reg, 1'h0, mode_reg};
                    `PMWC_OFF_RSTCAUSE: wb_dat_o <= {29'h0, cause_reg};
                    `PMWC_OFF_RETAIN: wb_dat_o <= {28'h0, retain_reg};
                    `PMWC_OFF_WAKEEN: wb_dat_o <= {29'h0, wakeen_reg};
                    `PMWC_OFF_CLKSEL: wb_dat_o <= {29'h0, clksel_reg};
                    `PMWC_OFF_GPIO: wb_dat_o <= {16'h0, gpio_hold_o};
                    default: wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end

    // configuration registers; lost across shutdown since shutdown resets them
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            req_reg <= 2'h0;
            retain_reg <= `PMWC_RETAIN_RST;
            wakeen_reg <= `PMWC_WAKEEN_RST;
            clksel_reg <= `PMWC_CLKSEL_RST;
        end
        else if (mode_reg == pmwc_pkg::PMWC_SHUTDOWN)
        begin
            req_reg <= 2'h0;
            retain_reg <= `PMWC_RETAIN_RST;
            wakeen_reg <= `PMWC_WAKEEN_RST;
            clksel_reg <= `PMWC_CLKSEL_RST;
        end
        else if (bus_req && wb_we_i && wb_sel_i[0])
        begin
            case (wb_adr_i)
                `PMWC_OFF_CTRL: req_reg <= wb_dat_i[1:0];
                `PMWC_OFF_RETAIN: retain_reg <= wb_dat_i[3:0];
                `PMWC_OFF_WAKEEN: wakeen_reg <= wb_dat_i[2:0];
                `PMWC_OFF_CLKSEL: clksel_reg <= wb_dat_i[2:0];
                default: ;
            endcase
        end
    end

    // mode sequencer
    always_comb
    begin
        mode_next = mode_reg;
        case (mode_reg)
            pmwc_pkg::PMWC_ACTIVE:
                if (go_pulse)
                    mode_next = pmwc_pkg::pmwc_mode_t'({1'b0, wb_dat_i[1:0]});
            pmwc_pkg::PMWC_IDLE:
                if (irq_s)
                    mode_next = pmwc_pkg::PMWC_WAKING;
            pmwc_pkg::PMWC_STANDBY:
                if ((rtc_s && wakeen_reg.rtc) || (pin_wake && wakeen_reg.pin) ||
                    (sensor_s && wakeen_reg.sensor))
                    mode_next = pmwc_pkg::PMWC_WAKING;
            pmwc_pkg::PMWC_SHUTDOWN:
                if (pin_wake)
                    mode_next = pmwc_pkg::PMWC_WAKING;
            pmwc_pkg::PMWC_WAKING:
                if (wait_reg == 20'h00001 && !droop_lock_reg)
                    mode_next = pmwc_pkg::PMWC_ACTIVE;
            default: mode_next = pmwc_pkg::PMWC_ACTIVE;
        endcase
        if (!rpin_s2)
            mode_next = pmwc_pkg::PMWC_WAKING;
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            mode_reg <= pmwc_pkg::PMWC_WAKING;
        else
            mode_reg <= mode_next;
    end

    // remember where the wake came from to choose the cpu reset
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            from_reg <= pmwc_pkg::PMWC_SHUTDOWN;
        else if (!rpin_s2)
            from_reg <= pmwc_pkg::PMWC_SHUTDOWN;
        else if (mode_reg != pmwc_pkg::PMWC_WAKING && mode_next == pmwc_pkg::PMWC_WAKING)
            from_reg <= mode_reg;
    end

    // wake delay counter
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            wait_reg <= 20'(`PMWC_CYC_SHUTDOWN);
        else if (!rpin_s2)
            wait_reg <= 20'(`PMWC_CYC_SHUTDOWN);
        else if (mode_reg != pmwc_pkg::PMWC_WAKING && mode_next == pmwc_pkg::PMWC_WAKING)
        begin
            case (mode_reg)
                pmwc_pkg::PMWC_IDLE: wait_reg <= 20'(`PMWC_CYC_IDLE);
                pmwc_pkg::PMWC_STANDBY: wait_reg <= 20'(`PMWC_CYC_STANDBY);
                default: wait_reg <= 20'(`PMWC_CYC_SHUTDOWN);
            endcase
        end
        else if (mode_reg == pmwc_pkg::PMWC_WAKING && wait_reg > 20'h00001)
            wait_reg <= wait_reg - 20'h00001;
    end

    // reset cause, held until the next reset event
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cause_reg <= 3'h1;
            rpin_seen_reg <= 1'h0;
        end
        else
        begin
            rpin_seen_reg <= !rpin_s2;
            if (!rpin_s2 && !rpin_seen_reg)
                cause_reg <= 3'h2;
            else if (mode_reg == pmwc_pkg::PMWC_SHUTDOWN && pin_wake)
                cause_reg <= 3'h4;
        end
    end

    // droop detector wake lock, set on low supply during recharge in standby
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            droop_lock_reg <= 1'h0;
        else if (!rpin_s2)
            droop_lock_reg <= 1'h0;
        else if (mode_reg == pmwc_pkg::PMWC_STANDBY && recharge_s && low_s)
            droop_lock_reg <= 1'h1;
    end

    // io latch, captured on entry to standby or shutdown
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            gpio_latch_o <= 1'h0;
            gpio_hold_o <= 16'h0000;
        end
        else
        begin
            if (mode_reg == pmwc_pkg::PMWC_ACTIVE && go_pulse && wb_dat_i[1])
                gpio_hold_o <= gpio_s2;
            gpio_latch_o <= (mode_next == pmwc_pkg::PMWC_STANDBY) ||
                            (mode_next == pmwc_pkg::PMWC_SHUTDOWN);
        end
    end

    // clock and power gating
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            gate_o <= 7'h0;
            sram_retain_o <= `PMWC_RETAIN_RST;
            cache_as_ram_o <= 1'h0;
            droop_det_en_o <= 1'h0;
            fast_clk_sel_xtal_o <= 1'h0;
            fast_pll_x2_en_o <= 1'h0;
            slow_clk_sel_xtal_o <= 1'h0;
            cpu_reset_o <= 1'h1;
            cpu_active_o <= 1'h0;
        end
        else
        begin
            gate_o.cpu_clk_en <= mode_next == pmwc_pkg::PMWC_ACTIVE;
            gate_o.mem_clk_en <= mode_next == pmwc_pkg::PMWC_ACTIVE;
            gate_o.periph_clk_en <= (mode_next == pmwc_pkg::PMWC_ACTIVE) ||
                                    (mode_next == pmwc_pkg::PMWC_IDLE);
            gate_o.flash_pwr_en <= (mode_next == pmwc_pkg::PMWC_ACTIVE) ||
                                   (mode_next == pmwc_pkg::PMWC_IDLE);
            gate_o.fast_osc_en <= (mode_next != pmwc_pkg::PMWC_STANDBY) &&
                                  (mode_next != pmwc_pkg::PMWC_SHUTDOWN);
            gate_o.aon_pwr_en <= mode_next != pmwc_pkg::PMWC_SHUTDOWN;
            gate_o.sensor_pwr_en <= mode_next != pmwc_pkg::PMWC_SHUTDOWN;
            sram_retain_o <= retain_reg;
            cache_as_ram_o <= clksel_reg[`PMWC_CLK_CACHE_OFF_BIT];
            droop_det_en_o <= (mode_next == pmwc_pkg::PMWC_STANDBY) ? recharge_s :
                              (mode_next != pmwc_pkg::PMWC_SHUTDOWN);
            fast_clk_sel_xtal_o <= clksel_reg[`PMWC_CLK_FAST_XTAL_BIT];
            fast_pll_x2_en_o <= clksel_reg[`PMWC_CLK_FAST_XTAL_BIT];
            slow_clk_sel_xtal_o <= clksel_reg[`PMWC_CLK_SLOW_XTAL_BIT] && xtal_s2;
            // standby wake resumes without a cpu reset; shutdown/reset-pin wakes restart
            // from_reg only follows on the entry edge, so look at mode_reg there
            cpu_reset_o <= (mode_next == pmwc_pkg::PMWC_SHUTDOWN) || !rpin_s2 ||
                           (mode_next == pmwc_pkg::PMWC_WAKING && (mode_reg == pmwc_pkg::PMWC_SHUTDOWN ||
                           (mode_reg == pmwc_pkg::PMWC_WAKING && from_reg == pmwc_pkg::PMWC_SHUTDOWN)));
            cpu_active_o <= mode_next == pmwc_pkg::PMWC_ACTIVE;
        end
    end

    // assertions
    AST_IDLE_GATES: assert property (@(posedge sys_clk) disable iff (!nrst)
        mode_reg == pmwc_pkg::PMWC_IDLE |-> !gate_o.cpu_clk_en && gate_o.periph_clk_en)
        else $error("idle gating wrong");
    AST_IDLE_IRQ: assert property (@(posedge sys_clk) disable iff (!nrst)
        mode_reg == pmwc_pkg::PMWC_IDLE && irq_s |=> mode_reg == pmwc_pkg::PMWC_WAKING)
        else $error("idle ignored interrupt");
    AST_STBY_HOLD: assert property (@(posedge sys_clk) disable iff (!nrst)
        mode_reg == pmwc_pkg::PMWC_STANDBY && !rtc_s && !sensor_s && !pin_wake && rpin_s2
        |=> mode_reg == pmwc_pkg::PMWC_STANDBY)
        else $error("standby left without wake");
    AST_LATCH: assert property (@(posedge sys_clk) disable iff (!nrst)
        mode_reg == pmwc_pkg::PMWC_STANDBY |-> gpio_latch_o &&
        ($stable(gpio_hold_o) || $past(mode_reg) == pmwc_pkg::PMWC_ACTIVE))
        else $error("gpio not latched");
    AST_AON_OFF: assert property (@(posedge sys_clk) disable iff (!nrst)
        $rose(mode_reg == pmwc_pkg::PMWC_SHUTDOWN) |-> !gate_o.aon_pwr_en && !gate_o.sensor_pwr_en)
        else $error("shutdown left domain powered");
    AST_SHUT_WAKE: assert property (@(posedge sys_clk) disable iff (!nrst)
        mode_reg == pmwc_pkg::PMWC_SHUTDOWN && pin_wake && rpin_s2 |=> cause_reg == 3'h4 && cpu_reset_o)
        else $error("shutdown wake not reset");
    AST_IDLE_WAIT: assert property (@(posedge sys_clk) disable iff (!nrst)
        mode_reg == pmwc_pkg::PMWC_IDLE && irq_s && rpin_s2 |=> wait_reg == 20'(`PMWC_CYC_IDLE))
        else $error("idle wake delay wrong");
    AST_CAUSE_HOLD: assert property (@(posedge sys_clk) disable iff (!nrst)
        rpin_s2 && $past(rpin_s2) && mode_reg != pmwc_pkg::PMWC_SHUTDOWN |=> $stable(cause_reg))
        else $error("reset cause changed");
    AST_DROOP: assert property (@(posedge sys_clk) disable iff (!nrst)
        mode_reg == pmwc_pkg::PMWC_STANDBY && mode_next == pmwc_pkg::PMWC_STANDBY
        |=> droop_det_en_o == $past(recharge_s))
        else $error("droop detector duty wrong");

    COV_IDLE: cover property (@(posedge sys_clk) disable iff (!nrst)
        mode_reg == pmwc_pkg::PMWC_IDLE ##1 mode_reg == pmwc_pkg::PMWC_WAKING);
    COV_STBY: cover property (@(posedge sys_clk) disable iff (!nrst)
        mode_reg == pmwc_pkg::PMWC_STANDBY ##1 mode_reg == pmwc_pkg::PMWC_WAKING);
    COV_SHUT: cover property (@(posedge sys_clk) disable iff (!nrst)
        mode_reg == pmwc_pkg::PMWC_SHUTDOWN && pin_wake);

endmodule : pmwc_top

// [pmwc_cfg.svh]
`ifndef PMWC_CFG_SVH
`define PMWC_CFG_SVH

// register byte offsets
`define PMWC_OFF_CTRL 8'h00
`define PMWC_OFF_STATUS 8'h04
`define PMWC_OFF_RSTCAUSE 8'h08
`define PMWC_OFF_RETAIN 8'h0C
`define PMWC_OFF_WAKEEN 8'h10
`define PMWC_OFF_CLKSEL 8'h14
`define PMWC_OFF_GPIO 8'h18

// ctrl register fields
`define PMWC_CTRL_REQ_LSB 0
`define PMWC_CTRL_GO_BIT 2

// clksel fields
`define PMWC_CLK_FAST_XTAL_BIT 0
`define PMWC_CLK_SLOW_XTAL_BIT 1
`define PMWC_CLK_CACHE_OFF_BIT 2

// wake enable fields
`define PMWC_WAKE_RTC_BIT 0
`define PMWC_WAKE_PIN_BIT 1
`define PMWC_WAKE_SENSOR_BIT 2

// reset values
`define PMWC_RETAIN_RST 4'hF
`define PMWC_WAKEEN_RST 3'h7
`define PMWC_CLKSEL_RST 3'h1

// timing
`define PMWC_CLK_MHZ 250
`define PMWC_T_IDLE_US 14
`define PMWC_T_STANDBY_US 151
`define PMWC_T_SHUTDOWN_US 1015
`define PMWC_CYC_IDLE (`PMWC_T_IDLE_US * `PMWC_CLK_MHZ)
`define PMWC_CYC_STANDBY (`PMWC_T_STANDBY_US * `PMWC_CLK_MHZ)
`define PMWC_CYC_SHUTDOWN (`PMWC_T_SHUTDOWN_US * `PMWC_CLK_MHZ)

`define PMWC_NUM_GPIO 16
`define PMWC_NUM_SRAM 4

`endif

// [pmwc_pkg.sv]
package pmwc_pkg;

    typedef enum logic [2:0] {
        PMWC_ACTIVE = 3'h0,
        PMWC_IDLE = 3'h1,
        PMWC_STANDBY = 3'h2,
        PMWC_SHUTDOWN = 3'h3,
        PMWC_WAKING = 3'h4
    } pmwc_mode_t;

    typedef enum logic [1:0] {
        PMWC_REQ_IDLE = 2'h1,
        PMWC_REQ_STANDBY = 2'h2,
        PMWC_REQ_SHUTDOWN = 2'h3
    } pmwc_req_t;

    // reset cause, one-hot so software can tell them apart
    typedef struct packed {
        logic wake_pin;
        logic reset_pin;
        logic power_on;
    } pmwc_cause_t;

    // gating outputs grouped per concern
    typedef struct packed {
        logic cpu_clk_en;
        logic mem_clk_en;
        logic periph_clk_en;
        logic aon_pwr_en;
        logic sensor_pwr_en;
        logic fast_osc_en;
        logic flash_pwr_en;
    } pmwc_gate_t;

    // packed msb first, so rtc lands on bit 0 of the wake enable word
    typedef struct packed {
        logic sensor;
        logic pin;
        logic rtc;
    } pmwc_wake_t;

endpackage : pmwc_pkg

// [pmwc_wake_model.sv]
`timescale 1ns/1ns
`include "pmwc_cfg.svh"

module pmwc_wake_model (
    // clock
    input wire logic sys_clk,
    // requests from the bench: irq, timer, sensor
    input wire logic [2:0] ev_req,
    input wire logic [`PMWC_NUM_GPIO-1:0] pin_val,
    // lines into the sequencer
    output logic irq_any,
    output logic rtc_event,
    output logic sensor_event,
    output logic [`PMWC_NUM_GPIO-1:0] gpio_in,
    output logic recharge_active,
    output logic supply_low
);
    logic [2:0] ev_reg = 3'h0;
    logic [3:0] cnt_reg = 4'h0;
    logic [5:0] tick_reg = 6'h00;

    // events stay up 9 cycles so the input synchroniser cannot miss them
    always @(posedge sys_clk)
    begin
        if (ev_req != 3'h0)
        begin
            ev_reg <= ev_req;
            cnt_reg <= 4'h8;
        end
        else if (cnt_reg != 4'h0)
            cnt_reg <= cnt_reg - 4'h1;
        else
            ev_reg <= 3'h0;
    end

    always @(posedge sys_clk)
        tick_reg <= tick_reg + 6'h01;

    assign irq_any = ev_reg[2];
    assign rtc_event = ev_reg[1];
    assign sensor_event = ev_reg[0];
    assign gpio_in = pin_val;
    // supply recharges in short bursts, as a duty-cycled regulator would
    assign recharge_active = (tick_reg[5:3] == 3'h7);
    // software keeps standby away from a weak supply, so no droop here
    assign supply_low = 1'b0;
endmodule : pmwc_wake_model

// [testbench.sv]
`timescale 1ns/1ns
`include "pmwc_cfg.svh"

module testbench;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0;
    logic [2:0] ev_req = 3'h0;
    logic [15:0] pin_val = 16'h0;
    logic [15:0] shutdown_wake_mask = 16'h0;
    logic reset_pin_n = 1'b1;
    logic slow_xtal_present = 1'b0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, wb_err_o, irq_any, rtc_event, sensor_event, recharge_active, supply_low;
    logic [15:0] gpio_in, gpio_hold_o;
    pmwc_pkg::pmwc_gate_t gate_o;
    logic [3:0] sram_retain_o;
    logic cache_as_ram_o, gpio_latch_o, droop_det_en_o, fast_clk_sel_xtal_o, fast_pll_x2_en_o;
    logic slow_clk_sel_xtal_o, cpu_reset_o, cpu_active_o;
    int n_errors = 0;
    int tests_run = 0;
    int seed = 40;
    int cnt;
    logic [33:0] exp_q[$];
    logic [33:0] note;
    logic [15:0] pins;
    logic [3:0] ret;

    always #2 sys_clk = ~sys_clk;

    pmwc_top i_dut (.sys_clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .wb_err_o, .irq_any, .rtc_event, .sensor_event, .reset_pin_n, .gpio_in,
        .shutdown_wake_mask, .recharge_active, .supply_low, .slow_xtal_present, .gate_o, .sram_retain_o,
        .cache_as_ram_o, .gpio_latch_o, .gpio_hold_o, .droop_det_en_o, .fast_clk_sel_xtal_o,
        .fast_pll_x2_en_o, .slow_clk_sel_xtal_o, .cpu_reset_o, .cpu_active_o);

    pmwc_wake_model i_far (.sys_clk, .ev_req, .pin_val, .irq_any, .rtc_event, .sensor_event, .gpio_in,
        .recharge_active, .supply_low);

    task automatic summarize;
        $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : summarize

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask : check

    // note[33] expects an error answer, note[32] asks for a data compare
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [33:0] n_exp);
        int n;
        exp_q.push_back(n_exp);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (!wb_ack_o && !wb_err_o && n < 40);
        check({31'h0, n < 40}, 32'h1, "bus answer");
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge sys_clk);
    endtask : wb

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0, 4'hF, {2'b01, e});
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        wb(1'b1, a, d, s, 34'h0);
    endtask : wr

    task automatic ev(input logic [2:0] r);
        ev_req <= r;
        @(posedge sys_clk);
        ev_req <= 3'h0;
    endtask : ev

    // wake latency: the window absorbs the input synchroniser and the request edge
    task automatic wait_active(input int lo, input string what);
        int n;
        n = 0;
        while (!cpu_active_o && n < lo + 64)
        begin
            @(posedge sys_clk);
            n++;
        end
        check({31'h0, n >= lo && n <= lo + 16}, 32'h1, what);
    endtask : wait_active

    always @(posedge sys_clk)
        if (wb_cyc_i && (wb_ack_o || wb_err_o))
        begin
            note = exp_q.pop_front();
            check({31'h0, wb_err_o}, {31'h0, note[33]}, "bus error flag");
            if (note[32])
                check(wb_dat_o, note[31:0], "read data");
        end

    initial
    begin
        repeat (420000) @(posedge sys_clk);
        n_errors++;
        $display("Error at %0t: run did not finish in time", $time);
        summarize();
    end

    initial
    begin
        repeat (8) @(posedge sys_clk);
        nrst <= 1'b1;
        wait_active(`PMWC_CYC_SHUTDOWN, "power-on wake delay");
        rd(`PMWC_OFF_RSTCAUSE, 32'h1);
        rd(`PMWC_OFF_RETAIN, 32'hF);
        rd(`PMWC_OFF_WAKEEN, 32'h7);
        rd(`PMWC_OFF_CLKSEL, 32'h1);
        rd(`PMWC_OFF_STATUS, 32'h0);
        wb(1'b0, 8'h40, 32'h0, 4'hF, {2'b10, 32'h0});
        check({28'h0, gate_o.cpu_clk_en, gate_o.mem_clk_en, gate_o.periph_clk_en, gate_o.aon_pwr_en}, 32'hF,
              "active gating");
        check({30'h0, fast_clk_sel_xtal_o, fast_pll_x2_en_o}, 32'h3, "fast crystal doubled");
        $display("test reset done");
        ret = 4'($random(seed));
        wr(`PMWC_OFF_RETAIN, {28'h0, ret}, 4'hF);
        wr(`PMWC_OFF_RETAIN, 32'h0, 4'hE);
        rd(`PMWC_OFF_RETAIN, {28'h0, ret});
        check({28'h0, sram_retain_o}, {28'h0, ret}, "retention outputs");
        wr(`PMWC_OFF_CLKSEL, 32'h6, 4'hF);
        @(posedge sys_clk);
        check({28'h0, cache_as_ram_o, slow_clk_sel_xtal_o, fast_clk_sel_xtal_o, fast_pll_x2_en_o}, 32'h8,
              "clock select, no slow crystal");
        slow_xtal_present <= 1'b1;
        repeat (4) @(posedge sys_clk);
        wr(`PMWC_OFF_CLKSEL, 32'h3, 4'hF);
        @(posedge sys_clk);
        check({28'h0, cache_as_ram_o, slow_clk_sel_xtal_o, fast_clk_sel_xtal_o, fast_pll_x2_en_o}, 32'h7,
              "clock select, slow crystal");
        rd(`PMWC_OFF_RSTCAUSE, 32'h1);
        $display("test registers done");
        wr(`PMWC_OFF_CTRL, 32'h5, 4'hF);
        repeat (2) @(posedge sys_clk);
        check({28'h0, gate_o.cpu_clk_en, gate_o.mem_clk_en, gate_o.periph_clk_en, cpu_active_o}, 32'h2,
              "idle gating");
        rd(`PMWC_OFF_STATUS, 32'h1);
        ev(3'h4);
        wait_active(`PMWC_CYC_IDLE, "idle wake delay");
        $display("test idle done");
        pins = 16'($random(seed));
        pin_val <= pins;
        repeat (4) @(posedge sys_clk);
        wr(`PMWC_OFF_WAKEEN, 32'h5, 4'hF);
        wr(`PMWC_OFF_CTRL, 32'h6, 4'hF);
        repeat (2) @(posedge sys_clk);
        check({15'h0, gpio_latch_o, gpio_hold_o}, {15'h0, 1'b1, pins}, "standby latch");
        pin_val <= ~pins;
        ev(3'h4);
        repeat (40) @(posedge sys_clk);
        check({16'h0, gpio_hold_o}, {16'h0, pins}, "standby hold");
        rd(`PMWC_OFF_STATUS, 32'h2);
        cnt = 0;
        repeat (128)
        begin
            @(posedge sys_clk);
            cnt += int'(droop_det_en_o);
        end
        check({31'h0, cnt > 0 && cnt < 128}, 32'h1, "droop detector duty cycled");
        ev(3'h2);
        wait_active(`PMWC_CYC_STANDBY, "standby timer wake delay");
        rd(`PMWC_OFF_RETAIN, {28'h0, ret});
        check({31'h0, gpio_latch_o}, 32'h0, "latch released");
        wr(`PMWC_OFF_WAKEEN, 32'h6, 4'hF);
        wr(`PMWC_OFF_CTRL, 32'h6, 4'hF);
        repeat (4) @(posedge sys_clk);
        ev(3'h2);
        repeat (40) @(posedge sys_clk);
        rd(`PMWC_OFF_STATUS, 32'h2);
        ev(3'h1);
        wait_active(`PMWC_CYC_STANDBY, "standby sensor wake delay");
        $display("test standby done");
        shutdown_wake_mask <= 16'h0001;
        wr(`PMWC_OFF_CTRL, 32'h7, 4'hF);
        repeat (2) @(posedge sys_clk);
        check({27'h0, gate_o.aon_pwr_en, gate_o.sensor_pwr_en, gate_o.cpu_clk_en, cpu_active_o, gpio_latch_o},
              32'h1, "shutdown power off");
        check({16'h0, gpio_hold_o}, {16'h0, ~pins}, "shutdown hold");
        ev(3'h2);
        repeat (40) @(posedge sys_clk);
        rd(`PMWC_OFF_STATUS, 32'h3);
        pin_val <= ~pins ^ 16'h0001;
        repeat (8) @(posedge sys_clk);
        rd(`PMWC_OFF_RSTCAUSE, 32'h4);
        rd(`PMWC_OFF_RETAIN, 32'hF);
        rd(`PMWC_OFF_STATUS, 32'h4);
        $display("test shutdown done");
        reset_pin_n <= 1'b0;
        repeat (8) @(posedge sys_clk);
        rd(`PMWC_OFF_RSTCAUSE, 32'h2);
        check({30'h0, cpu_reset_o, cpu_active_o}, 32'h2, "reset pin holds cpu");
        reset_pin_n <= 1'b1;
        $display("test reset pin done");
        summarize();
    end
endmodule : testbench
